// ### verilog/mds_pkg.sv
// How it works
// RULE1 - Unsigned minimum; nine-bit immediate zero-extended first
// RULE2 - Sixteen-bit immediate copy is sign-extended
// RULE3 - Four-bit immediate data copy is sign-extended
// RULE4 - Eight-bit immediate zero-extended into register 15
// RULE5 - Data or zero-extended immediate into address register
// RULE6 - Address register copied whole to address register
// RULE7 - Address register copied whole to data register
// RULE8 - Unsigned sixteen-bit load is zero-extended
// RULE9 - High data load: immediate high, low cleared
// RULE10 - High address load: immediate high, low cleared
// RULE11 - Signed product subtracted from 32/64-bit accumulator
// RULE12 - Nine-bit multiplier immediate is sign-extended
// RULE13 - Multiply-subtract updates all four overflow flags
// RULE14 - Saturating forms clamp to destination signed range
// RULE15 - Two halfword products from two accumulator halves
// RULE16 - Four halfword operand pairings are supported
// RULE17 - Shift one: 0x8000 squared gives special value
// RULE18 - Packed saturation applies to each half independently
// RULE19 - Word fraction: shifted product bits 63:32 subtracted
// RULE20 - Packed operands signed; shift only zero or one
// RULE21 - Sticky flags hold until cleared; others latest
// RULE22 - Wide results in even/odd pair, even low
package mds_pkg;

    typedef enum logic [4:0] {
        MDS_OP_MIN_U       = 5'h00,
        MDS_OP_MIN_U_IMM   = 5'h01,
        MDS_OP_COPY_D      = 5'h02,
        MDS_OP_COPY_IMM16  = 5'h03,
        MDS_OP_COPY_IMM4   = 5'h04,
        MDS_OP_COPY_IMM8   = 5'h05,
        MDS_OP_D_TO_A      = 5'h06,
        MDS_OP_IMM4_TO_A   = 5'h07,
        MDS_OP_A_TO_A      = 5'h08,
        MDS_OP_A_TO_D      = 5'h09,
        MDS_OP_LOAD_U16    = 5'h0A,
        MDS_OP_HIGH_D      = 5'h0B,
        MDS_OP_HIGH_A      = 5'h0C,
        MDS_OP_MSUB32      = 5'h0D,
        MDS_OP_MSUB32_IMM  = 5'h0E,
        MDS_OP_MSUB64      = 5'h0F,
        MDS_OP_MSUB64_IMM  = 5'h10,
        MDS_OP_MSUB_HALF   = 5'h11,
        MDS_OP_MSUB_FRAC32 = 5'h12
    } mds_op_e;

    localparam logic [1:0]  PAIR_UU_LL = 2'h0;
    localparam logic [1:0]  PAIR_UL_LU = 2'h1;
    localparam logic [1:0]  PAIR_UL_LL = 2'h2;
    localparam logic [1:0]  PAIR_LU_UU = 2'h3;

    localparam logic [3:0]  IMPLICIT_DATA_REG = 4'hF;
    localparam int          HALF_POS          = 16;

    localparam logic [31:0] MAX32        = 32'h7FFFFFFF;
    localparam logic [31:0] MIN32        = 32'h80000000;
    localparam logic [63:0] MAX64        = 64'h7FFFFFFFFFFFFFFF;
    localparam logic [63:0] MIN64        = 64'h8000000000000000;
    localparam logic [15:0] HALF_MIN     = 16'h8000;
    localparam logic [31:0] FRAC_SPECIAL = 32'h7FFFFFFF;

    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    localparam logic [3:0]  INDEX_RESET  = 4'h0;
    localparam logic        FLAG_RESET   = 1'b0;

endpackage : mds_pkg

// ### verilog/mds_half_lane.sv
`timescale 1ns/10ps
module mds_half_lane (
    // Operands
    input  wire logic [15:0] op_x,
    input  wire logic [15:0] op_y,
    input  wire logic [31:0] acc,
    // Mode
    input  wire logic        shift_one,
    input  wire logic        saturate,
    // Result
    output logic      [31:0] result,
    output logic             overflow,
    output logic             adv_overflow
);

    logic signed [31:0] product;
    logic        [32:0] prod_shift;
    logic        [31:0] sub;
    logic               special;
    logic        [33:0] exact;
    logic               ovf;

    assign product    = 32'($signed(op_x)) * 32'($signed(op_y));     // [RULE20]
    assign prod_shift = shift_one ? {product, 1'b0} : {product[31], product};
    assign special    = shift_one && (op_x == mds_pkg::HALF_MIN) && (op_y == mds_pkg::HALF_MIN);
    assign sub        = special ? mds_pkg::FRAC_SPECIAL : prod_shift[31:0]; // [RULE17]
    assign exact      = {{2{acc[31]}}, acc} - {{2{sub[31]}}, sub};     // [RULE15]
    assign ovf        = ~((&exact[33:31]) | (~|exact[33:31]));
    assign overflow   = ovf;
    assign adv_overflow = exact[31] ^ exact[30];
    // Each lane clamps on its own overflow only
    assign result     = (saturate && ovf) ? (exact[33] ? mds_pkg::MIN32 : mds_pkg::MAX32)
                                          : exact[31:0];              // [RULE18]

endmodule : mds_half_lane

// ### verilog/mds_word_msub.sv
`timescale 1ns/10ps
module mds_word_msub (
    // Operands
    input  wire logic [31:0] mul_a,
    input  wire logic [31:0] mul_b,
    input  wire logic [63:0] acc,
    // Mode
    input  wire logic        wide,
    input  wire logic        frac,
    input  wire logic        shift_one,
    input  wire logic        saturate,
    // Result
    output logic      [63:0] result,
    output logic             overflow,
    output logic             adv_overflow
);

    logic signed [63:0] product;
    logic        [64:0] prod_shift;
    logic        [65:0] sub;
    logic        [65:0] acc_ext;
    logic        [65:0] exact;
    logic               ovf32;
    logic               ovf64;
    logic               ovf;
    logic        [63:0] sat_val;

    assign product    = 64'($signed(mul_a)) * 64'($signed(mul_b));
    assign prod_shift = shift_one ? {product, 1'b0} : {product[63], product};
    assign sub        = frac ? {{34{prod_shift[63]}}, prod_shift[63:32]}  // [RULE19]
                             : {{2{product[63]}}, product};                 // [RULE11]
    assign acc_ext    = wide ? {{2{acc[63]}}, acc} : {{34{acc[31]}}, acc[31:0]};
    assign exact      = acc_ext - sub;
    assign ovf32      = ~((&exact[65:31]) | (~|exact[65:31]));
    assign ovf64      = ~((&exact[65:63]) | (~|exact[65:63]));
    assign ovf        = wide ? ovf64 : ovf32;
    assign overflow   = ovf;                                                // [RULE13]
    assign adv_overflow = wide ? (exact[63] ^ exact[62]) : (exact[31] ^ exact[30]);
    assign sat_val    = wide ? (exact[65] ? mds_pkg::MIN64 : mds_pkg::MAX64)
                             : {32'h00000000, (exact[65] ? mds_pkg::MIN32 : mds_pkg::MAX32)};
    assign result     = (saturate && ovf) ? sat_val                          // [RULE14]
                                          : (wide ? exact[63:0] : {32'h00000000, exact[31:0]});

endmodule : mds_word_msub

// ### verilog/mds_datapath.sv
`timescale 1ns/10ps
module mds_datapath (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Request from decode
    input  wire logic        op_valid,
    input  wire logic [4:0]  op_code,
    input  wire logic        saturate,
    input  wire logic        shift_one,
    input  wire logic [1:0]  pairing,
    input  wire logic [3:0]  dest_index,
    input  wire logic [15:0] immediate,
    // Operands from register file
    input  wire logic [31:0] src_a_data,
    input  wire logic [31:0] src_b_data,
    input  wire logic [31:0] src_addr,
    input  wire logic [31:0] acc_lo,
    input  wire logic [31:0] acc_hi,
    // Status control
    input  wire logic        sticky_clear,
    // Write-back to register file
    output logic             done_q,
    output logic             data_we_q,
    output logic             data_pair_we_q,
    output logic             addr_we_q,
    output logic      [3:0]  dest_index_q,
    output logic      [31:0] result_lo_q,
    output logic      [31:0] result_hi_q,
    // Status flags
    output logic             overflow_flag_q,
    output logic             sticky_overflow_flag_q,
    output logic             advanced_overflow_flag_q,
    output logic             sticky_advanced_overflow_flag_q
);

    mds_pkg::mds_op_e op;
    assign op = mds_pkg::mds_op_e'(op_code);

    // Immediate extensions
    logic [31:0] four_bit_imm_sext;
    logic [31:0] four_bit_imm_zext;
    logic [31:0] eight_bit_imm_zext;
    logic [31:0] nine_bit_imm_zext;
    logic [31:0] nine_bit_imm_sext;
    logic [31:0] sixteen_bit_imm_sext;
    logic [31:0] sixteen_bit_imm_zext;
    logic [31:0] sixteen_bit_imm_high;

    assign four_bit_imm_sext    = {{28{immediate[3]}}, immediate[3:0]};    // [RULE3]
    assign four_bit_imm_zext    = {28'h0000000, immediate[3:0]};           // [RULE5]
    assign eight_bit_imm_zext   = {24'h000000, immediate[7:0]};            // [RULE4]
    assign nine_bit_imm_zext    = {23'h000000, immediate[8:0]};            // [RULE1]
    assign nine_bit_imm_sext    = {{23{immediate[8]}}, immediate[8:0]};    // [RULE12]
    assign sixteen_bit_imm_sext = {{16{immediate[15]}}, immediate};        // [RULE2]
    assign sixteen_bit_imm_zext = {16'h0000, immediate};                   // [RULE8]
    assign sixteen_bit_imm_high = {immediate, 16'h0000};                   // [RULE9] [RULE10]

    // Unsigned minimum
    logic [31:0] min_b;
    logic [31:0] min_result;
    assign min_b      = (op == mds_pkg::MDS_OP_MIN_U_IMM) ? nine_bit_imm_zext : src_b_data;
    assign min_result = (src_a_data < min_b) ? src_a_data : min_b;          // [RULE1]

    // Word multiply-subtract
    logic        is_word_imm;
    logic        is_wide;
    logic        is_frac;
    logic [31:0] word_mul_b;
    logic [63:0] word_result;
    logic        word_ovf;
    logic        word_adv;

    assign is_word_imm = (op == mds_pkg::MDS_OP_MSUB32_IMM) || (op == mds_pkg::MDS_OP_MSUB64_IMM);
    assign is_wide     = (op == mds_pkg::MDS_OP_MSUB64) || (op == mds_pkg::MDS_OP_MSUB64_IMM);
    assign is_frac     = (op == mds_pkg::MDS_OP_MSUB_FRAC32);
    assign word_mul_b  = is_word_imm ? nine_bit_imm_sext : src_b_data;     // [RULE12]

    mds_word_msub u_word (
        .mul_a        (src_a_data),
        .mul_b        (word_mul_b),
        .acc          ({acc_hi, acc_lo}),
        .wide         (is_wide),
        .frac         (is_frac),
        .shift_one    (shift_one),
        .saturate     (saturate),
        .result       (word_result),
        .overflow     (word_ovf),
        .adv_overflow (word_adv)
    );

    // Packed halfword operand selection
    logic [15:0] a_hi;
    logic [15:0] a_lo;
    logic [15:0] b_hi;
    logic [15:0] b_lo;
    logic [15:0] lane_x   [2];
    logic [15:0] lane_y   [2];
    logic [31:0] lane_acc [2];
    logic [31:0] lane_res [2];
    logic [1:0]  lane_ovf;
    logic [1:0]  lane_adv;

    assign a_hi = src_a_data[31:mds_pkg::HALF_POS];
    assign a_lo = src_a_data[mds_pkg::HALF_POS-1:0];
    assign b_hi = src_b_data[31:mds_pkg::HALF_POS];
    assign b_lo = src_b_data[mds_pkg::HALF_POS-1:0];

    // Lane 1 feeds the high accumulator word, lane 0 the low one
    assign lane_x[1] = (pairing == mds_pkg::PAIR_LU_UU) ? a_lo : a_hi;     // [RULE16]
    assign lane_y[1] = (pairing == mds_pkg::PAIR_UU_LL) ? b_hi :
                       (pairing == mds_pkg::PAIR_LU_UU) ? b_hi : b_lo;
    assign lane_x[0] = (pairing == mds_pkg::PAIR_LU_UU) ? a_hi : a_lo;
    assign lane_y[0] = (pairing == mds_pkg::PAIR_UL_LU) ? b_hi :
                       (pairing == mds_pkg::PAIR_LU_UU) ? b_hi : b_lo;
    assign lane_acc[1] = acc_hi;
    assign lane_acc[0] = acc_lo;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            mds_half_lane u_lane (
                .op_x         (lane_x[gi]),
                .op_y         (lane_y[gi]),
                .acc          (lane_acc[gi]),
                .shift_one    (shift_one),
                .saturate     (saturate),
                .result       (lane_res[gi]),
                .overflow     (lane_ovf[gi]),
                .adv_overflow (lane_adv[gi])
            );
        end
    endgenerate

    // Operation decode
    logic        is_msub;
    logic        d_we;
    logic        d_pair;
    logic        a_we;
    logic [3:0]  d_index;
    logic [31:0] d_lo;
    logic [31:0] d_hi;
    logic        flag_v;
    logic        flag_av;

    always_comb begin
        is_msub = 1'b0;
        d_we    = 1'b0;
        d_pair  = 1'b0;
        a_we    = 1'b0;
        d_index = dest_index;
        d_lo    = mds_pkg::RESULT_RESET;
        d_hi    = mds_pkg::RESULT_RESET;
        flag_v  = 1'b0;
        flag_av = 1'b0;
        case (op)
            mds_pkg::MDS_OP_MIN_U, mds_pkg::MDS_OP_MIN_U_IMM: begin
                d_we = 1'b1;
                d_lo = min_result;                                    // [RULE1]
            end
            mds_pkg::MDS_OP_COPY_D: begin
                d_we = 1'b1;
                d_lo = src_b_data;
            end
            mds_pkg::MDS_OP_COPY_IMM16: begin
                d_we = 1'b1;
                d_lo = sixteen_bit_imm_sext;                          // [RULE2]
            end
            mds_pkg::MDS_OP_COPY_IMM4: begin
                d_we = 1'b1;
                d_lo = four_bit_imm_sext;                             // [RULE3]
            end
            mds_pkg::MDS_OP_COPY_IMM8: begin
                d_we    = 1'b1;
                d_index = mds_pkg::IMPLICIT_DATA_REG;                 // [RULE4]
                d_lo    = eight_bit_imm_zext;
            end
            mds_pkg::MDS_OP_D_TO_A: begin
                a_we = 1'b1;
                d_lo = src_b_data;                                    // [RULE5]
            end
            mds_pkg::MDS_OP_IMM4_TO_A: begin
                a_we = 1'b1;
                d_lo = four_bit_imm_zext;                             // [RULE5]
            end
            mds_pkg::MDS_OP_A_TO_A: begin
                a_we = 1'b1;
                d_lo = src_addr;                                      // [RULE6]
            end
            mds_pkg::MDS_OP_A_TO_D: begin
                d_we = 1'b1;
                d_lo = src_addr;                                      // [RULE7]
            end
            mds_pkg::MDS_OP_LOAD_U16: begin
                d_we = 1'b1;
                d_lo = sixteen_bit_imm_zext;                          // [RULE8]
            end
            mds_pkg::MDS_OP_HIGH_D: begin
                d_we = 1'b1;
                d_lo = sixteen_bit_imm_high;                          // [RULE9]
            end
            mds_pkg::MDS_OP_HIGH_A: begin
                a_we = 1'b1;
                d_lo = sixteen_bit_imm_high;                          // [RULE10]
            end
            mds_pkg::MDS_OP_MSUB32, mds_pkg::MDS_OP_MSUB32_IMM,
            mds_pkg::MDS_OP_MSUB_FRAC32: begin
                is_msub = 1'b1;
                d_we    = 1'b1;
                d_lo    = word_result[31:0];                          // [RULE11]
                flag_v  = word_ovf;
                flag_av = word_adv;
            end
            mds_pkg::MDS_OP_MSUB64, mds_pkg::MDS_OP_MSUB64_IMM: begin
                is_msub = 1'b1;
                d_we    = 1'b1;
                d_pair  = 1'b1;
                d_index = {dest_index[3:1], 1'b0};                    // [RULE22]
                d_lo    = word_result[31:0];
                d_hi    = word_result[63:32];
                flag_v  = word_ovf;
                flag_av = word_adv;
            end
            mds_pkg::MDS_OP_MSUB_HALF: begin
                is_msub = 1'b1;
                d_we    = 1'b1;
                d_pair  = 1'b1;
                d_index = {dest_index[3:1], 1'b0};                    // [RULE22]
                d_lo    = lane_res[0];                                // [RULE15]
                d_hi    = lane_res[1];
                flag_v  = |lane_ovf;                                  // [RULE13]
                flag_av = |lane_adv;
            end
            default: begin
                d_we = 1'b0;
            end
        endcase
    end

    // Flag next values; a set in the clearing cycle wins
    logic flag_update;
    logic v_d;
    logic av_d;
    logic sv_d;
    logic sav_d;

    assign flag_update = op_valid && is_msub;
    assign v_d   = flag_update ? flag_v  : overflow_flag_q;             // [RULE21]
    assign av_d  = flag_update ? flag_av : advanced_overflow_flag_q;    // [RULE13]
    assign sv_d  = (sticky_overflow_flag_q && !sticky_clear) || (flag_update && flag_v);            // [RULE21]
    assign sav_d = (sticky_advanced_overflow_flag_q && !sticky_clear) || (flag_update && flag_av);  // [RULE21]

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            done_q         <= 1'b0;
            data_we_q      <= 1'b0;
            data_pair_we_q <= 1'b0;
            addr_we_q      <= 1'b0;
            dest_index_q   <= mds_pkg::INDEX_RESET;
            result_lo_q    <= mds_pkg::RESULT_RESET;
            result_hi_q    <= mds_pkg::RESULT_RESET;
        end else begin
            done_q         <= op_valid;
            data_we_q      <= op_valid && d_we;
            data_pair_we_q <= op_valid && d_pair;
            addr_we_q      <= op_valid && a_we;
            if (op_valid) begin
                dest_index_q <= d_index;
                result_lo_q  <= d_lo;
                result_hi_q  <= d_hi;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            overflow_flag_q                 <= mds_pkg::FLAG_RESET;
            advanced_overflow_flag_q        <= mds_pkg::FLAG_RESET;
            sticky_overflow_flag_q          <= mds_pkg::FLAG_RESET;
            sticky_advanced_overflow_flag_q <= mds_pkg::FLAG_RESET;
        end else begin
            overflow_flag_q                 <= v_d;
            advanced_overflow_flag_q        <= av_d;
            sticky_overflow_flag_q          <= sv_d;
            sticky_advanced_overflow_flag_q <= sav_d;
        end
    end

endmodule : mds_datapath

// ### bench/mds_regfile_model.sv
`timescale 1ns/10ps
module mds_regfile_model (
    // Clock
    input  logic        clock,
    // Write-back from the datapath
    input  logic        data_we,
    input  logic        pair_we,
    input  logic        addr_we,
    input  logic [3:0]  index,
    input  logic [31:0] lo,
    input  logic [31:0] hi
);
    logic [31:0] data_q [16];
    logic [31:0] addr_q [16];

    always @(posedge clock) begin
        if (data_we) begin
            data_q[index] <= lo;
        end
        if (pair_we) begin
            data_q[index + 4'h1] <= hi;
        end
        if (addr_we) begin
            addr_q[index] <= lo;
        end
    end
endmodule : mds_regfile_model

// ### bench/mds_datapath_asserts.sv
`timescale 1ns/10ps
module mds_datapath_asserts (
    // Clock and reset
    input  logic        clock,
    input  logic        resetn,
    // Request
    input  logic        op_valid,
    input  logic [4:0]  op_code,
    input  logic [15:0] immediate,
    input  logic [31:0] src_a_data,
    input  logic [31:0] src_b_data,
    input  logic [31:0] src_addr,
    input  logic        sticky_clear,
    // Write-back and flags
    input  logic        data_we_q,
    input  logic        data_pair_we_q,
    input  logic        addr_we_q,
    input  logic [3:0]  dest_index_q,
    input  logic [31:0] result_lo_q,
    input  logic        overflow_flag_q,
    input  logic        sticky_overflow_flag_q
);
    logic [15:0] imm_q;
    logic [31:0] a_q;
    logic [31:0] b_q;
    logic [31:0] addr_q;

    // Operands of the previous request
    always_ff @(posedge clock) begin
        imm_q  <= immediate;
        a_q    <= src_a_data;
        b_q    <= src_b_data;
        addr_q <= src_addr;
    end

    function automatic logic taken(input logic [4:0] code);
        return op_valid && op_code == code;
    endfunction : taken

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    a_imm8_dest: assert property (taken(mds_pkg::MDS_OP_COPY_IMM8) |=> data_we_q
        && dest_index_q == mds_pkg::IMPLICIT_DATA_REG && result_lo_q == {24'h000000, imm_q[7:0]})
        else $error("eight-bit copy wrong");
    a_pair_even: assert property (taken(mds_pkg::MDS_OP_MSUB64) || taken(mds_pkg::MDS_OP_MSUB64_IMM)
        |=> data_we_q && data_pair_we_q && !dest_index_q[0]) else $error("pair write wrong");
    a_high_data: assert property (taken(mds_pkg::MDS_OP_HIGH_D) |=> data_we_q
        && result_lo_q == {imm_q, 16'h0000}) else $error("high data load wrong");
    a_imm16_sext: assert property (taken(mds_pkg::MDS_OP_COPY_IMM16) |=>
        result_lo_q == {{16{imm_q[15]}}, imm_q}) else $error("sixteen-bit copy wrong");
    a_addr_copy: assert property (taken(mds_pkg::MDS_OP_A_TO_A) |=> addr_we_q && !data_we_q
        && result_lo_q == addr_q) else $error("address copy wrong");
    a_min_unsigned: assert property (taken(mds_pkg::MDS_OP_MIN_U) |=>
        result_lo_q == ((a_q < b_q) ? a_q : b_q)) else $error("unsigned minimum wrong");
    a_sticky_hold: assert property (sticky_overflow_flag_q && !sticky_clear |=>
        sticky_overflow_flag_q) else $error("sticky flag lost");
    a_sticky_set: assert property ($rose(overflow_flag_q) |-> sticky_overflow_flag_q)
        else $error("sticky flag not set");
    a_flags_keep: assert property (op_valid && op_code < mds_pkg::MDS_OP_MSUB32 |=>
        $stable(overflow_flag_q)) else $error("move changed overflow");

    c_pair: cover property (taken(mds_pkg::MDS_OP_MSUB64) ##1 data_pair_we_q);
    c_overflow: cover property ($rose(overflow_flag_q));
    c_clear: cover property (sticky_clear ##1 !sticky_overflow_flag_q);
endmodule : mds_datapath_asserts

bind mds_datapath mds_datapath_asserts mds_datapath_asserts_inst (.clock, .resetn, .op_valid, .op_code,
    .immediate, .src_a_data, .src_b_data, .src_addr, .sticky_clear, .data_we_q, .data_pair_we_q, .addr_we_q,
    .dest_index_q, .result_lo_q, .overflow_flag_q, .sticky_overflow_flag_q);

// ### bench/mds_datapath_tb_top.sv
`timescale 1ns/10ps
module mds_datapath_tb_top;
    logic        clock, resetn, op_valid, saturate, shift_one, sticky_clear;
    logic        done_q, data_we_q, data_pair_we_q, addr_we_q, ov_q, sov_q, aov_q, saov_q;
    logic [1:0]  pairing;
    logic [3:0]  dest_index, dest_index_q;
    logic [4:0]  op_code;
    logic [15:0] immediate;
    logic [31:0] src_a_data, src_b_data, src_addr, acc_lo, acc_hi, result_lo_q, result_hi_q;
    int          mismatches;
    int          total_checks;
    int          ph [4] = '{-10, -14, -14, 15};
    int          pl [4] = '{21, 15, 21, -10};

    always #50 clock = ~clock;

    mds_datapath mds_datapath_inst (.clock, .resetn, .op_valid, .op_code, .saturate, .shift_one, .pairing,
        .dest_index, .immediate, .src_a_data, .src_b_data, .src_addr, .acc_lo, .acc_hi, .sticky_clear, .done_q,
        .data_we_q, .data_pair_we_q, .addr_we_q, .dest_index_q, .result_lo_q, .result_hi_q, .overflow_flag_q(ov_q),
        .sticky_overflow_flag_q(sov_q), .advanced_overflow_flag_q(aov_q), .sticky_advanced_overflow_flag_q(saov_q));

    mds_regfile_model mds_regfile_model_inst (.clock(clock), .data_we(data_we_q), .pair_we(data_pair_we_q),
        .addr_we(addr_we_q), .index(dest_index_q), .lo(result_lo_q), .hi(result_hi_q));

    task automatic chk(input string what, input logic [63:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic opnd(input logic [31:0] a, b, ad, lo, hi);
        src_a_data = a;
        src_b_data = b;
        src_addr   = ad;
        acc_lo     = lo;
        acc_hi     = hi;
    endtask : opnd

    // Answer is read at the next falling edge
    task automatic issue(input logic [4:0] op, input logic [15:0] imm, input logic [3:0] dst);
        op_code    = op;
        immediate  = imm;
        dest_index = dst;
        op_valid   = 1'b1;
        @(negedge clock);
        chk("done_q", 64'h1, 64'(done_q));
    endtask : issue

    task automatic mv(input logic [4:0] op, input logic [15:0] imm, input logic [31:0] exp, input logic aw);
        issue(op, imm, 4'h3);
        chk("result_lo_q", 64'(exp), 64'(result_lo_q));
        chk("dest_index_q", (op == mds_pkg::MDS_OP_COPY_IMM8) ? 64'hF : 64'h3, 64'(dest_index_q));
        chk("addr_we_q", 64'(aw), 64'(addr_we_q));
        chk("data_we_q", 64'(!aw), 64'(data_we_q));
    endtask : mv

    task automatic msb(input logic [4:0] op, input logic sat, sh, input logic [1:0] pr,
                       input logic [15:0] imm, input logic [31:0] hi, lo, input logic v);
        saturate  = sat;
        shift_one = sh;
        pairing   = pr;
        issue(op, imm, 4'h5);
        chk("result_hi_q", 64'(hi), 64'(result_hi_q));
        chk("result_lo_q", 64'(lo), 64'(result_lo_q));
        chk("overflow_flag_q", 64'(v), 64'(ov_q));
    endtask : msb

    task automatic results();
        $display("Total checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    initial begin
        clock        = 1'b0;
        resetn       = 1'b0;
        sticky_clear = 1'b0;
        saturate     = 1'b0;
        shift_one    = 1'b0;
        pairing      = 2'h0;
        op_valid     = 1'b0;
        op_code      = 5'h00;
        dest_index   = 4'h0;
        immediate    = 16'h0000;
        opnd(32'hFFFFFFFF, 32'h1, 32'hC0DE1234, 32'h0, 32'h0);
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        mv(mds_pkg::MDS_OP_MIN_U, 16'h0, 32'h1, 1'b0);
        mv(mds_pkg::MDS_OP_MIN_U_IMM, 16'h01FF, 32'h1FF, 1'b0);
        mv(mds_pkg::MDS_OP_COPY_D, 16'h0, 32'h1, 1'b0);
        mv(mds_pkg::MDS_OP_COPY_IMM16, 16'h8ACE, 32'hFFFF8ACE, 1'b0);
        mv(mds_pkg::MDS_OP_COPY_IMM4, 16'h0058, 32'hFFFFFFF8, 1'b0);
        mv(mds_pkg::MDS_OP_COPY_IMM8, 16'h12FE, 32'hFE, 1'b0);
        mv(mds_pkg::MDS_OP_D_TO_A, 16'h0, 32'h1, 1'b1);
        mv(mds_pkg::MDS_OP_IMM4_TO_A, 16'h003F, 32'hF, 1'b1);
        mv(mds_pkg::MDS_OP_A_TO_A, 16'h0, 32'hC0DE1234, 1'b1);
        mv(mds_pkg::MDS_OP_A_TO_D, 16'h0, 32'hC0DE1234, 1'b0);
        mv(mds_pkg::MDS_OP_LOAD_U16, 16'h8ACE, 32'h8ACE, 1'b0);
        mv(mds_pkg::MDS_OP_HIGH_D, 16'h8ACE, 32'h8ACE0000, 1'b0);
        mv(mds_pkg::MDS_OP_HIGH_A, 16'h8ACE, 32'h8ACE0000, 1'b1);
        chk("model d15", 64'hFE, 64'(mds_regfile_model_inst.data_q[15]));
        $display("Test moves finished");
        opnd(32'h3, 32'h4, 32'h0, 32'hA, 32'h0);
        msb(mds_pkg::MDS_OP_MSUB32, 1'b0, 1'b0, 2'h0, 16'h0, 32'h0, 32'hFFFFFFFE, 1'b0);
        msb(mds_pkg::MDS_OP_MSUB32_IMM, 1'b0, 1'b0, 2'h0, 16'h01FF, 32'h0, 32'hD, 1'b0);
        opnd(32'h2, 32'h3, 32'h0, 32'h0, 32'h0);
        msb(mds_pkg::MDS_OP_MSUB64, 1'b0, 1'b0, 2'h0, 16'h0, 32'hFFFFFFFF, 32'hFFFFFFFA, 1'b0);
        msb(mds_pkg::MDS_OP_MSUB64_IMM, 1'b0, 1'b0, 2'h0, 16'h01FE, 32'h0, 32'h4, 1'b0);
        chk("dest_index_q", 64'h4, 64'(dest_index_q));
        opnd(32'h40000000, 32'h40000000, 32'h0, 32'h30000000, 32'h0);
        msb(mds_pkg::MDS_OP_MSUB_FRAC32, 1'b0, 1'b1, 2'h0, 16'h0, 32'h0, 32'h10000000, 1'b0);
        chk("model pair", 64'h4, {mds_regfile_model_inst.data_q[5], mds_regfile_model_inst.data_q[4]});
        msb(mds_pkg::MDS_OP_MSUB_FRAC32, 1'b0, 1'b0, 2'h0, 16'h0, 32'h0, 32'h20000000, 1'b0);
        opnd(32'hFFFE0003, 32'h00050007, 32'h0, 32'd200, 32'd100);
        for (int i = 0; i < 4; i++) begin
            msb(mds_pkg::MDS_OP_MSUB_HALF, 1'b0, 1'b0, 2'(i), 16'h0, 32'(100 - ph[i]), 32'(200 - pl[i]), 1'b0);
        end
        opnd(32'h80008000, 32'h80008000, 32'h0, 32'h0, 32'h0);
        msb(mds_pkg::MDS_OP_MSUB_HALF, 1'b0, 1'b1, 2'h0, 16'h0, 32'h80000001, 32'h80000001, 1'b0);
        opnd(32'h00010001, 32'h00010001, 32'h0, 32'h5, 32'h80000000);
        msb(mds_pkg::MDS_OP_MSUB_HALF, 1'b1, 1'b0, 2'h0, 16'h0, 32'h80000000, 32'h4, 1'b1);
        $display("Test arithmetic finished");
        opnd(32'h1, 32'h1, 32'h0, 32'h80000000, 32'h0);
        msb(mds_pkg::MDS_OP_MSUB32, 1'b0, 1'b0, 2'h0, 16'h0, 32'h0, 32'h7FFFFFFF, 1'b1);
        chk("flags", 64'h7, {61'h0, aov_q, sov_q, saov_q});
        msb(mds_pkg::MDS_OP_MSUB32, 1'b1, 1'b0, 2'h0, 16'h0, 32'h0, 32'h80000000, 1'b1);
        opnd(32'h3, 32'h4, 32'h0, 32'hA, 32'h0);
        msb(mds_pkg::MDS_OP_MSUB32, 1'b0, 1'b0, 2'h0, 16'h0, 32'h0, 32'hFFFFFFFE, 1'b0);
        chk("sticky flags", 64'h3, {62'h0, sov_q, saov_q});
        issue(5'h1F, 16'h0, 4'h1);
        chk("write enables", 64'h0, {62'h0, data_we_q, addr_we_q});
        op_valid     = 1'b0;
        sticky_clear = 1'b1;
        @(negedge clock);
        sticky_clear = 1'b0;
        chk("cleared flags", 64'h0, {62'h0, sov_q, saov_q});
        $display("Test flags finished");
        results();
    end
endmodule : mds_datapath_tb_top
